// [tcic_event_src.sv]
// model: event pin, comparator output and count pin outside the timer
`timescale 1ns/10ps
`default_nettype none
module tcic_event_src (
    input wire logic clk,
    input wire logic want_cap,
    input wire logic want_cmp,
    input wire logic want_ext,
    output logic capture_pin,
    output logic comparator_output,
    output logic external_count_pin
);
    // levels move mid-cycle, away from the sampling edge, as a real pin would
    always @(negedge clk) begin
        capture_pin <= want_cap;
        comparator_output <= want_cmp;
        external_count_pin <= want_ext;
    end
endmodule
`default_nettype wire

// [tcic_pin_sync.sv]
// module: three-stage pin synchroniser with optional four-sample noise filter
`timescale 1ns/10ps
`default_nettype none

module tcic_pin_sync (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic pin_in,
    input wire logic filter_en,
    output logic level_out
);

    typedef struct packed {
        logic [tcic_pkg::SYNC_LEN-1:0] sync;
        logic lvl;
        logic [tcic_pkg::FILT_LEN-1:0] hist;
        logic filt;
    } tcic_sync_s;

    tcic_sync_s r;
    tcic_sync_s n;
    logic lvl_now;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // stage 0 feeds only stage 1; the level moves once stages 1 and 2 agree
    // no extra register after the agreement, so pin to count stays near 3.5 cycles
    always_comb begin
        n = r;
        n.sync = {r.sync[1:0], pin_in};
        lvl_now = r.lvl;
        if (r.sync[1] == r.sync[2]) begin
            lvl_now = r.sync[2];
        end
        n.lvl = lvl_now;
        // filter: four equal samples are needed before the output flips
        n.hist = {r.hist[tcic_pkg::FILT_LEN-2:0], lvl_now};
        if (n.hist == tcic_pkg::FILT_ONES || n.hist == tcic_pkg::FILT_RST) begin
            n.filt = n.hist[0];
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // filter runs on the system clock, never on the prescaler
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else if (clk_en) begin
            r <= n;
        end
    end

    // filter path adds four cycles in front of the edge detector
    assign level_out = filter_en ? r.filt : lvl_now;

endmodule

`default_nettype wire

// [tcic_pkg.sv]
// package: constants, modes and carrier structs of the timer/counter with input capture
package tcic_pkg;

    // ------------------------------------------------------------
    // clock source codes
    // ------------------------------------------------------------
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    // ------------------------------------------------------------
    // prescaler and counter constants
    // ------------------------------------------------------------
    localparam int PRE_W = 10;
    localparam logic [PRE_W-1:0] PRE_ONE = 10'h001;
    localparam logic [PRE_W-1:0] PRE_M8 = 10'h007;
    localparam logic [PRE_W-1:0] PRE_M64 = 10'h03f;
    localparam logic [PRE_W-1:0] PRE_M256 = 10'h0ff;
    localparam logic [PRE_W-1:0] PRE_M1024 = 10'h3ff;
    localparam logic [PRE_W-1:0] PRE_RST = 10'h000;
    localparam logic [7:0] MAX8 = 8'hff;
    localparam logic [15:0] MAX16 = 16'hffff;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [7:0] ONE8 = 8'h01;
    localparam logic [15:0] ONE16 = 16'h0001;

    // ------------------------------------------------------------
    // pin synchroniser and noise filter
    // ------------------------------------------------------------
    localparam int SYNC_LEN = 3;
    localparam int FILT_LEN = 4;
    localparam logic [SYNC_LEN-1:0] SYNC_RST = 3'h0;
    localparam logic [FILT_LEN-1:0] FILT_RST = 4'h0;
    localparam logic [FILT_LEN-1:0] FILT_ONES = 4'hf;

    // modes, gray coded along normal -> ctc -> w16 -> capture path
    typedef enum logic [2:0] {
        TCIC_M_NORM8 = 3'h0,
        TCIC_M_CTC8 = 3'h1,
        TCIC_M_W16 = 3'h3,
        TCIC_M_CAP8 = 3'h2,
        TCIC_M_CAP16 = 3'h6
    } tcic_mode_e;

    // static control bits
    typedef struct packed {
        logic [2:0] clock_source_select;
        logic capture_enable;
        logic width_select;
        logic clear_on_match_select;
        logic comparator_trigger_select;
        logic noise_filter_enable;
        logic capture_edge_rising;
        logic capture_irq_enable;
        logic overflow_irq_enable;
    } tcic_ctrl_s;

    // processor write strobes with their data, and flag clears
    typedef struct packed {
        logic count_wr;
        logic [15:0] count_data;
        logic comp_a_wr;
        logic [7:0] comp_a_data;
        logic comp_b_wr;
        logic [7:0] comp_b_data;
        logic ovf_w1c;
        logic ovf_ack;
        logic cap_w1c;
        logic cap_ack;
    } tcic_cpu_s;

    // prescaler tap pulses
    typedef struct packed {
        logic div8;
        logic div64;
        logic div256;
        logic div1024;
    } tcic_pre_s;

endpackage

// [tcic_prescaler.sv]
// module: free running prescaler giving divide-by-8/64/256/1024 pulses
`timescale 1ns/10ps
`default_nettype none

module tcic_prescaler (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    output tcic_pkg::tcic_pre_s taps
);

    typedef struct packed {
        logic [tcic_pkg::PRE_W-1:0] cnt;
    } tcic_prs_s;

    tcic_prs_s r;
    tcic_prs_s n;

    // a tap fires when all its low counter bits are ones
    function automatic logic tap_hit(input logic [tcic_pkg::PRE_W-1:0] c,
                                     input logic [tcic_pkg::PRE_W-1:0] m);
        tap_hit = ((c & m) == m);
    endfunction

    // ------------------------------------------------------------
    // next state and taps
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        n.cnt = r.cnt + tcic_pkg::PRE_ONE;
    end

    // taps share one counter, so slower ticks line up with faster ones
    assign taps.div8 = tap_hit(r.cnt, tcic_pkg::PRE_M8);
    assign taps.div64 = tap_hit(r.cnt, tcic_pkg::PRE_M64);
    assign taps.div256 = tap_hit(r.cnt, tcic_pkg::PRE_M256);
    assign taps.div1024 = tap_hit(r.cnt, tcic_pkg::PRE_M1024);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r.cnt <= tcic_pkg::PRE_RST;
        end else if (clk_en) begin
            r <= n;
        end
    end

endmodule

`default_nettype wire

// [tcic_props.sv]
// checker: port properties of the timer with input capture
`timescale 1ns/10ps
`default_nettype none
module tcic_props (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire tcic_pkg::tcic_ctrl_s ctrl,
    input wire tcic_pkg::tcic_cpu_s cpu,
    input wire logic external_count_pin,
    input wire logic capture_pin,
    input wire logic comparator_output,
    input wire logic [15:0] count_value,
    input wire logic [7:0] compare_a_value,
    input wire logic [7:0] compare_b_value,
    input wire logic overflow_flag,
    input wire logic capture_flag,
    input wire logic overflow_irq,
    input wire logic capture_irq
);
    // ----------
    // properties
    // ----------
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // mode field, and a /1 tick that no cpu write overrides
    wire logic [2:0] md = {ctrl.capture_enable, ctrl.width_select, ctrl.clear_on_match_select};
    wire logic run1 = clk_en && !cpu.count_wr && ctrl.clock_source_select == 3'h1;
    wire logic [7:0] lo = count_value[7:0];

    stop_hold_a: assert property (
        clk_en && !cpu.count_wr && ctrl.clock_source_select == 3'h0 |=> $stable(count_value))
        else $error("count moved while stopped");
    write_wins_a: assert property (
        clk_en && cpu.count_wr |=> count_value == $past(cpu.count_data))
        else $error("count write lost");
    norm_step_a: assert property (
        run1 && md == 3'h0 |=> lo == $past(lo) + 8'h01 && $stable(count_value[15:8]))
        else $error("normal step wrong");
    norm_ovf_a: assert property (
        run1 && md == 3'h0 && lo == 8'hff |=> overflow_flag)
        else $error("no overflow on wrap");
    ovf_sticky_a: assert property (
        overflow_flag && !cpu.ovf_w1c && !cpu.ovf_ack |=> overflow_flag)
        else $error("overflow flag dropped");
    ctc_clear_a: assert property (
        run1 && md == 3'h1 && lo == compare_a_value |=> lo == 8'h00)
        else $error("no clear on match");
    cap_stamp_a: assert property (
        $rose(capture_flag) |-> compare_a_value == $past(lo))
        else $error("capture value wrong");
    cap_irq_a: assert property (
        clk_en |=> capture_irq == $past(capture_flag && ctrl.capture_irq_enable))
        else $error("capture irq wrong");

    // main scenarios reached
    cover property ($rose(capture_flag));
    cover property ($rose(overflow_flag));
    cover property (run1 && md == 3'h1 && lo == compare_a_value);
endmodule
`default_nettype wire

// [tcic_timer.sv]
// module: 8/16-bit timer/counter with input capture, top level
`timescale 1ns/10ps
`default_nettype none

module tcic_timer (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire tcic_pkg::tcic_ctrl_s ctrl,
    input wire tcic_pkg::tcic_cpu_s cpu,
    input wire logic external_count_pin,
    input wire logic capture_pin,
    input wire logic comparator_output,
    output logic [15:0] count_value,
    output logic [7:0] compare_a_value,
    output logic [7:0] compare_b_value,
    output logic overflow_flag,
    output logic capture_flag,
    output logic overflow_irq,
    output logic capture_irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] count;
        logic [7:0] comp_a;
        logic [7:0] comp_b;
        logic ovf;
        logic cap;
        logic ovf_irq;
        logic cap_irq;
        logic ext_prev;
        logic trig_prev;
    } tcic_state_s;

    tcic_state_s r;
    tcic_state_s n;

    tcic_pkg::tcic_pre_s taps;
    tcic_pkg::tcic_mode_e mode;
    logic ext_lvl;
    logic icp_lvl;
    logic aco_lvl;
    logic trig_lvl;
    logic ext_rise;
    logic ext_fall;
    logic trig_edge;
    logic tick;
    logic cap_evt;
    logic ovf_set;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    // width and capture bits override clear-on-match
    function automatic tcic_pkg::tcic_mode_e mode_of(input tcic_pkg::tcic_ctrl_s c);
        if (c.capture_enable && c.width_select) begin
            mode_of = tcic_pkg::TCIC_M_CAP16;
        end else if (c.capture_enable) begin
            mode_of = tcic_pkg::TCIC_M_CAP8;
        end else if (c.width_select) begin
            mode_of = tcic_pkg::TCIC_M_W16;
        end else if (c.clear_on_match_select) begin
            mode_of = tcic_pkg::TCIC_M_CTC8;
        end else begin
            mode_of = tcic_pkg::TCIC_M_NORM8;
        end
    endfunction

    // rising or falling edge of a level against its previous sample
    function automatic logic edge_of(input logic cur, input logic prev, input logic rising);
        edge_of = rising ? (cur & ~prev) : (~cur & prev);
    endfunction

    // ------------------------------------------------------------
    // input conditioning
    // ------------------------------------------------------------
    // count pin never filtered; 3 stages + edge give about three and a half cycles
    tcic_pin_sync u_sync_ext (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .pin_in(external_count_pin),
        .filter_en(1'b0),
        .level_out(ext_lvl)
    );

    // capture inputs use the same synchroniser, with the filter option
    tcic_pin_sync u_sync_icp (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .pin_in(capture_pin),
        .filter_en(ctrl.noise_filter_enable),
        .level_out(icp_lvl)
    );

    tcic_pin_sync u_sync_aco (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .pin_in(comparator_output),
        .filter_en(ctrl.noise_filter_enable),
        .level_out(aco_lvl)
    );

    tcic_prescaler u_pre (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .taps(taps)
    );

    // ------------------------------------------------------------
    // trigger and tick selection
    // ------------------------------------------------------------
    // source mux sits before the edge detector, so a switch can fake an edge
    assign trig_lvl = ctrl.comparator_trigger_select ? aco_lvl : icp_lvl;
    assign trig_edge = edge_of(trig_lvl, r.trig_prev, ctrl.capture_edge_rising);
    assign ext_rise = edge_of(ext_lvl, r.ext_prev, 1'b1);
    assign ext_fall = edge_of(ext_lvl, r.ext_prev, 1'b0);
    assign mode = mode_of(ctrl);
    assign cap_evt = ctrl.capture_enable & trig_edge;

    // tick source decode; code zero stops the counter
    always_comb begin
        case (ctrl.clock_source_select)
            tcic_pkg::CS_STOP: tick = 1'b0;
            tcic_pkg::CS_DIV1: tick = 1'b1;
            tcic_pkg::CS_DIV8: tick = taps.div8;
            tcic_pkg::CS_DIV64: tick = taps.div64;
            tcic_pkg::CS_DIV256: tick = taps.div256;
            tcic_pkg::CS_DIV1024: tick = taps.div1024;
            tcic_pkg::CS_EXT_FALL: tick = ext_fall;
            tcic_pkg::CS_EXT_RISE: tick = ext_rise;
            default: tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        ovf_set = 1'b0;
        n.ext_prev = ext_lvl;
        n.trig_prev = trig_lvl;

        // counter: a processor write wins over clear and increment
        if (cpu.count_wr) begin
            n.count = cpu.count_data;
        end else if (tick) begin
            case (mode)
                tcic_pkg::TCIC_M_W16, tcic_pkg::TCIC_M_CAP16: begin
                    // full 16-bit roll over, flag on reaching zero
                    n.count = r.count + tcic_pkg::ONE16;
                    ovf_set = (r.count == tcic_pkg::MAX16);
                end
                tcic_pkg::TCIC_M_CTC8: begin
                    // compare A acts as TOP; a TOP below count is passed
                    if (r.count[7:0] == r.comp_a) begin
                        n.count[7:0] = tcic_pkg::ZERO8;
                    end else begin
                        n.count[7:0] = r.count[7:0] + tcic_pkg::ONE8;
                    end
                    ovf_set = (r.count[7:0] == tcic_pkg::MAX8);
                end
                tcic_pkg::TCIC_M_NORM8, tcic_pkg::TCIC_M_CAP8: begin
                    // low byte only, high byte untouched
                    n.count[7:0] = r.count[7:0] + tcic_pkg::ONE8;
                    ovf_set = (r.count[7:0] == tcic_pkg::MAX8);
                end
                default: begin
                    n.count = r.count;
                end
            endcase
        end

        // compare registers load straight away, no shadow copy
        if (cpu.comp_a_wr) begin
            n.comp_a = cpu.comp_a_data;
        end
        if (cpu.comp_b_wr) begin
            n.comp_b = cpu.comp_b_data;
        end

        // capture overwrites unread data; beats a same-cycle compare write
        if (cap_evt) begin
            n.comp_a = r.count[7:0];
            if (mode == tcic_pkg::TCIC_M_CAP16) begin
                n.comp_b = r.count[15:8];
            end
        end

        // flags: only hardware sets; the set wins over a clear in the same cycle
        n.ovf = (r.ovf & ~(cpu.ovf_w1c | cpu.ovf_ack)) | ovf_set;
        n.cap = (r.cap & ~(cpu.cap_w1c | cpu.cap_ack)) | cap_evt;

        // requests follow the flags one cycle later to keep outputs registered
        n.ovf_irq = r.ovf & ctrl.overflow_irq_enable;
        n.cap_irq = r.cap & ctrl.capture_irq_enable;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // clock enable low freezes everything, prescaler and filters included
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else if (clk_en) begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // all outputs are plain state bits; compare A also reads back captures, compare B only in 16-bit capture mode
    assign count_value = r.count;
    assign compare_a_value = r.comp_a;
    assign compare_b_value = r.comp_b;
    assign overflow_flag = r.ovf;
    assign capture_flag = r.cap;
    assign overflow_irq = r.ovf_irq;
    assign capture_irq = r.cap_irq;

endmodule

`default_nettype wire

// [testbench.sv]
// bench: directed scenarios for the timer with input capture
`timescale 1ns/10ps
`default_nettype none
module testbench;
    logic clk, arst_n, clk_en, w_cap, w_cmp, w_ext, cap_pin, cmp_out, ext_pin;
    logic overflow_flag, capture_flag, overflow_irq, capture_irq;
    logic [15:0] count_value;
    logic [7:0] compare_a_value, compare_b_value;
    tcic_pkg::tcic_ctrl_s ctrl;
    tcic_pkg::tcic_cpu_s cpu;
    int n_errors, check_count, cyc;

    // design and its pin source
    tcic_timer u_dut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .ctrl(ctrl), .cpu(cpu),
        .external_count_pin(ext_pin), .capture_pin(cap_pin), .comparator_output(cmp_out),
        .count_value(count_value), .compare_a_value(compare_a_value), .compare_b_value(compare_b_value),
        .overflow_flag(overflow_flag), .capture_flag(capture_flag), .overflow_irq(overflow_irq),
        .capture_irq(capture_irq));
    tcic_event_src u_src (.clk(clk), .want_cap(w_cap), .want_cmp(w_cmp), .want_ext(w_ext),
        .capture_pin(cap_pin), .comparator_output(cmp_out), .external_count_pin(ext_pin));

    // ----------
    // helpers
    // ----------
    // inputs change 5 ns after the edge so no race with sampling
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #5;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one-cycle strobe, then an idle edge so strobes never meet in one step
    task automatic cpu_op(input tcic_pkg::tcic_cpu_s c);
        cpu = c;
        step(1);
        cpu = '0;
        step(1);
    endtask
    task automatic wr_cnt(input logic [15:0] d);
        cpu_op({1'b1, d, 22'h0});
    endtask
    task automatic flg(input logic [3:0] f);
        cpu_op({35'h0, f});
    endtask
    // flag bits: capture, width, ctc, comparator, filter, rising, cap irq, ovf irq
    task automatic cfg(input logic [2:0] cs, input logic [7:0] f);
        ctrl = {cs, f};
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ----------
    // scenarios
    // ----------
    task automatic s_stop();
        cfg(3'h0, 8'h00);
        wr_cnt(16'h0042);
        chk("cnt_wr", count_value, 16'h0042);
        step(20);
        chk("stopped", count_value, 16'h0042);
        cfg(3'h1, 8'h00);
        clk_en = 1'b0;
        step(5);
        chk("frozen", count_value, 16'h0042);
        cfg(3'h0, 8'h00);
        clk_en = 1'b1;
        step(1);
    endtask
    task automatic s_norm();
        cfg(3'h0, 8'h01);
        wr_cnt(16'h12fd);
        cfg(3'h1, 8'h01);
        step(3);
        chk("wrap8", count_value, 16'h1200);
        chk("ovf8", 16'(overflow_flag), 16'h0001);
        step(5);
        chk("ovf_kept", 16'(overflow_flag), 16'h0001);
        chk("ovf_irq", 16'(overflow_irq), 16'h0001);
        flg(4'h4);
        chk("ovf_ack", 16'(overflow_flag), 16'h0000);
        chk("ovf_irq_off", 16'(overflow_irq), 16'h0000);
    endtask
    task automatic s_ctc();
        cfg(3'h0, 8'h21);
        cpu_op({17'h0, 1'b1, 8'h03, 13'h0});
        chk("cmp_now", 16'(compare_a_value), 16'h0003);
        wr_cnt(16'h0000);
        cfg(3'h1, 8'h21);
        step(4);
        chk("ctc_clr", count_value, 16'h0000);
        chk("ctc_no_ovf", 16'(overflow_flag), 16'h0000);
        cfg(3'h0, 8'h21);
        wr_cnt(16'h00f0);
        cfg(3'h1, 8'h21);
        step(16);
        chk("ctc_past", count_value, 16'h0000);
        chk("ctc_ovf", 16'(overflow_flag), 16'h0001);
    endtask
    task automatic s_w16();
        cfg(3'h1, 8'h40);
        flg(4'h8);
        chk("ovf_w1c", 16'(overflow_flag), 16'h0000);
        wr_cnt(16'hfffe);
        chk("wr_wins", count_value, 16'hffff);
        step(1);
        chk("wrap16", count_value, 16'h0000);
        chk("ovf16", 16'(overflow_flag), 16'h0001);
    endtask
    // any 2048 edges hold exactly 2048/N prescaler ticks
    task automatic s_div();
        int sh[5] = '{0, 3, 6, 8, 10};
        cfg(3'h0, 8'h40);
        for (int c = 1; c < 6; c++) begin
            wr_cnt(16'h0000);
            cfg(3'(c), 8'h40);
            step(2048);
            cfg(3'h0, 8'h40);
            chk("div", count_value, 16'(2048 >> sh[c-1]));
        end
    endtask
    task automatic s_ext();
        wr_cnt(16'h0000);
        cfg(3'h7, 8'h40);
        w_ext = 1'b1;
        step(2);
        chk("ext_early", count_value, 16'h0000);
        step(2);
        chk("ext_rise", count_value, 16'h0001);
        cfg(3'h6, 8'h40);
        w_ext = 1'b0;
        step(6);
        chk("ext_fall", count_value, 16'h0002);
    endtask
    task automatic s_cap();
        cfg(3'h0, 8'hc6);
        wr_cnt(16'ha5c3);
        w_cap = 1'b1;
        step(6);
        chk("cap16", {compare_b_value, compare_a_value}, 16'ha5c3);
        chk("cap_irq", 16'(capture_irq), 16'h0001);
        wr_cnt(16'h1234);
        w_cap = 1'b0;
        step(6);
        chk("fall_skip", 16'(compare_a_value), 16'h00c3);
        w_cap = 1'b1;
        step(6);
        chk("overwrite", {compare_b_value, compare_a_value}, 16'h1234);
        flg(4'h2);
        chk("cap_w1c", 16'(capture_flag), 16'h0000);
    endtask
    // source switch may fire a capture, so the flag is cleared after each change
    task automatic s_src();
        cfg(3'h0, 8'hd6);
        step(8);
        flg(4'h1);
        wr_cnt(16'h0077);
        w_cap = 1'b0;
        step(6);
        w_cap = 1'b1;
        step(6);
        chk("pin_off", 16'(capture_flag), 16'h0000);
        w_cmp = 1'b1;
        step(6);
        chk("cmp_trig", 16'(compare_a_value), 16'h0077);
        cfg(3'h0, 8'hde);
        step(8);
        flg(4'h2);
        w_cmp = 1'b0;
        step(2);
        w_cmp = 1'b1;
        step(12);
        chk("glitch", 16'(capture_flag), 16'h0000);
        w_cmp = 1'b0;
        step(12);
        w_cmp = 1'b1;
        step(6);
        chk("filt_wait", 16'(capture_flag), 16'h0000);
        step(6);
        chk("filt_edge", 16'(capture_flag), 16'h0001);
    endtask

    // ----------
    // clock, reset, sequence
    // ----------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        arst_n = 1'b0;
        clk_en = 1'b1;
        {w_cap, w_cmp, w_ext} = 3'h0;
        ctrl = '0;
        cpu = '0;
        repeat (4) @(posedge clk);
        #5;
        arst_n = 1'b1;
        step(1);
        s_stop();
        s_norm();
        s_ctc();
        s_w16();
        s_div();
        s_ext();
        s_cap();
        s_src();
        give_verdict();
    end
    // hang guard: the sequence needs about 10.4k cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_errors++;
            give_verdict();
        end
    end
endmodule

bind tcic_timer tcic_props u_props (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .ctrl(ctrl), .cpu(cpu),
    .external_count_pin(external_count_pin), .capture_pin(capture_pin), .comparator_output(comparator_output),
    .count_value(count_value), .compare_a_value(compare_a_value), .compare_b_value(compare_b_value),
    .overflow_flag(overflow_flag), .capture_flag(capture_flag), .overflow_irq(overflow_irq),
    .capture_irq(capture_irq));
`default_nettype wire
